// ==== e1_sa_bit_error_monitor.sv ====
// receive sa-bit capture, sa6 error counters and signalling pointers
//
// How it works
// (R1) Non-PRBS: counter 2 counts submultiframes whose Sa6 is 0001 or 0011, CRC format only.
// (R2) Counter 2 Sa6 counting happens only while multiframe alignment holds.
// (R3) Sa6 nibble is built in arrival order, first bit from frame 1 or 9.
// (R4) Alarm simulation bumps Sa6 counters once per submultiframe, saturating.
// (R5) PRBS mode: counter 2 counts PRBS bit errors while in sync, saturating.
// (R6) PRBS mode alarm simulation counts every second received bit.
// (R7) Host sets the freeze request before reading a counter in buffer mode.
// (R8) Buffer follows counter; freeze rise stops it and clears counter; high read clears request.
// (R9) Per-second mode latches then clears each counter on every second event.
// (R10) Counter 3 counts submultiframes with Sa6 0010 or 0011, aligned CRC format.
// (R11) Counter 3 alt mode: bits 7..2 count multiframes while alignment lost.
// (R12) Counter 3 alt mode: bits 1..0 count alignment changes, saturating.
// (R13) Alt mode alarm simulation advances both fields once per multiframe.
// (R14) Five Sa capture registers reload from last multiframe at multiframe begin.
// (R15) Capture bit 0 comes from frame 1, bit 7 from frame 15.
// (R16) Sa6 groups classify as 1000, 1010, 1100, 1110, 1111 or other.
// (R17) A class sets its status bit after three successive detections.
// (R18) Sa6 status bits are sticky until read; read clears them.
// (R19) Each change of detected Sa6 class raises the changed pulse.
// (R20) No Sa6 status update while basic frame alignment is lost.
// (R21) Sync detect mode limits Sa6 updates to multiframe-aligned state.
// (R22) Low signalling pointer flags updates of registers 1..8; pointers reset zero.
// (R23) High signalling pointer flags updates of registers 9..16, bit 0 is 9.
// (R24) Multiframe begin marks each 2 ms CRC multiframe start.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module e1_sa_bit_error_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [e1_sa_monitor_pkg::ADDR_W-1:0] paddr,
	input wire logic [e1_sa_monitor_pkg::DATA_W-1:0] pwdata,
	output logic [e1_sa_monitor_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sa_strobe,
	input wire logic [3:0] frame_number,
	input wire logic [4:0] sa_bits,
	input wire logic multiframe_begin_event,
	input wire logic frame_align_lost,
	input wire logic multiframe_align_lost,
	input wire logic alignment_change,
	input wire logic rx_bit_strobe,
	input wire logic prbs_bit_error,
	input wire logic prbs_sync_indication,
	input wire logic one_second_event,
	input wire logic signalling_update,
	input wire logic [3:0] signalling_index,
	output logic sixth_spare_changed_event
);
	import e1_sa_monitor_pkg::*;

	typedef struct packed {
		logic [5:0] ctrl;
		logic [1:0] freeze;
		logic [1:0] freeze_d;
		logic [1:0][15:0] cnt;
		logic [1:0][15:0] buff;
		logic [4:0][7:0] sa_work;
		logic [4:0][7:0] sa_reg;
		logic [3:0] nib;
		logic bit_phase;
		logic [7:0] signalling_low_changed_bits;
		logic [7:0] signalling_high_changed_bits;
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} mon_t;

	mon_t st;
	mon_t next_st;
	logic [5:0] sa6_clear;
	logic [5:0] sa6_status;
	logic sa6_changed;

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		return (v == CNT_MAX) ? v : v + 16'h0001;
	endfunction : sat_inc

	// decoded line-side events
	logic service_frame;
	logic smf_first;
	logic smf_end;
	logic [3:0] nib_now;
	assign service_frame = sa_strobe && frame_number[0];
	assign smf_first = (frame_number == FRAME_SMF1_FIRST) || (frame_number == FRAME_SMF2_FIRST);
	assign smf_end = service_frame &&
		((frame_number == FRAME_SMF1_LAST) || (frame_number == FRAME_SMF2_LAST));
	assign nib_now = {st.nib[2:0], sa_bits[2]}; // see (R3)

	sa6_pattern_detector u_sa6_detector (
		.pclk(pclk),
		.presetn(presetn),
		.sa6_strobe(service_frame),
		.sa6_bit(sa_bits[2]),
		.smf_first(smf_first),
		.frame_align_lost(frame_align_lost),
		.multiframe_align_lost(multiframe_align_lost),
		.sixth_spare_sync_detect(st.ctrl[CTL_SA6_SYNC]),
		.clear_mask(sa6_clear),
		.status(sa6_status),
		.changed(sa6_changed)
	);

	function automatic logic [7:0] read_mux(input mon_t s, input logic [9:0] idx,
		input logic [5:0] sa6s);
		logic [7:0] v;
		v = 8'h00;
		for (int k = 0; k < 5; k++) begin
			if (idx == IDX_RX_SA4 + 10'(k)) begin
				v = s.sa_reg[k];
			end
		end
		unique case (idx)
			IDX_SA6_STATUS: v = {2'b00, sa6s};
			IDX_SIG_FLAGS_LOW: v = s.signalling_low_changed_bits;
			IDX_SIG_FLAGS_HIGH: v = s.signalling_high_changed_bits;
			IDX_CNT2_LOW: v = s.buff[0][7:0];
			IDX_CNT2_HIGH: v = s.buff[0][15:8];
			IDX_CNT3_LOW: v = s.buff[1][7:0];
			IDX_CNT3_HIGH: v = s.buff[1][15:8];
			IDX_CONTROL: v = {2'b00, s.ctrl};
			IDX_FREEZE: v = {6'h00, s.freeze};
			default: v = v;
		endcase
		return v;
	endfunction : read_mux

	function automatic logic idx_hit(input logic [9:0] idx);
		return (idx >= IDX_RX_SA4 && idx <= IDX_SIG_FLAGS_HIGH) ||
			(idx >= IDX_CNT2_LOW && idx <= IDX_FREEZE);
	endfunction : idx_hit

	always_comb begin
		logic [9:0] idx;
		logic crc_fmt;
		logic alarm;
		logic [1:0][15:0] bumped;
		logic [1:0] rise;
		logic inc2;
		logic inc3;
		logic [5:0] mf_cnt;
		logic [1:0] al_cnt;
		logic rd_done;
		idx = paddr[ADDR_W-1:2];
		inc2 = 1'b0;
		inc3 = 1'b0;
		bumped = '0;
		rise = 2'h0;
		mf_cnt = 6'h00;
		al_cnt = 2'h0;
		next_st = st;
		sa6_clear = 6'h00;
		rd_done = 1'b0;
		crc_fmt = st.ctrl[CTL_CRC_FORMAT];
		alarm = st.ctrl[CTL_ALARM_SIM];

		// apb: one wait state, effects at the completing edge
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		if (psel && penable && !st.pready) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !idx_hit(idx);
			next_st.prdata = {24'h000000, read_mux(st, idx, sa6_status)};
		end else if (psel && penable && st.pready) begin
			rd_done = !pwrite;
			if (pwrite && idx == IDX_CONTROL) begin
				next_st.ctrl = pwdata[5:0];
			end
			if (pwrite && idx == IDX_FREEZE) begin
				next_st.freeze = pwdata[1:0];
			end
		end
		if (rd_done) begin
			unique case (idx)
				IDX_SA6_STATUS: sa6_clear = st.prdata[5:0]; // see (R18)
				IDX_SIG_FLAGS_LOW:
					next_st.signalling_low_changed_bits = st.signalling_low_changed_bits &
						~st.prdata[7:0];
				IDX_SIG_FLAGS_HIGH:
					next_st.signalling_high_changed_bits = st.signalling_high_changed_bits &
						~st.prdata[7:0];
				IDX_CNT2_HIGH: next_st.freeze[0] = 1'b0; // see (R8)
				IDX_CNT3_HIGH: next_st.freeze[1] = 1'b0; // see (R8)
				default: next_st.freeze = next_st.freeze;
			endcase
		end

		// signalling update pointers, set wins over the read clear
		if (signalling_update && !signalling_index[3]) begin
			next_st.signalling_low_changed_bits[signalling_index[2:0]] = 1'b1; // see (R22)
		end
		if (signalling_update && signalling_index[3]) begin
			next_st.signalling_high_changed_bits[signalling_index[2:0]] = 1'b1; // see (R23)
		end

		// sa bit capture over one multiframe
		if (service_frame) begin
			next_st.nib = nib_now;
			for (int k = 0; k < 5; k++) begin
				next_st.sa_work[k][frame_number[3:1]] = sa_bits[k]; // see (R15)
			end
		end
		if (multiframe_begin_event) begin
			next_st.sa_reg = st.sa_work; // see (R14) see (R24)
		end

		// counter 2 increment source
		if (rx_bit_strobe) begin
			next_st.bit_phase = !st.bit_phase;
		end
		if (st.ctrl[CTL_PRBS_MODE]) begin
			inc2 = alarm ? (rx_bit_strobe && st.bit_phase) : // see (R6)
				(prbs_bit_error && prbs_sync_indication); // see (R5)
		end else begin
			inc2 = crc_fmt && smf_end && (alarm || (!multiframe_align_lost && // see (R1) see (R2) see (R4)
				(nib_now == SEQ_REMOTE || nib_now == SEQ_BOTH)));
		end
		bumped[0] = inc2 ? sat_inc(st.cnt[0]) : st.cnt[0];

		// counter 3 increment source
		inc3 = crc_fmt && smf_end && (alarm || (!multiframe_align_lost && // see (R10) see (R4)
			(nib_now == SEQ_LOCAL || nib_now == SEQ_BOTH)));
		mf_cnt = st.cnt[1][7:2];
		al_cnt = st.cnt[1][1:0];
		if (st.ctrl[CTL_CNT3_MODE]) begin
			if (multiframe_begin_event && mf_cnt != MF_CNT_MAX &&
				(alarm || frame_align_lost || multiframe_align_lost)) begin
				mf_cnt = mf_cnt + 6'h01; // see (R11) see (R13)
			end
			if ((alarm ? multiframe_begin_event : alignment_change) && al_cnt != ALIGN_CNT_MAX) begin
				al_cnt = al_cnt + 2'h1; // see (R12) see (R13)
			end
			bumped[1] = {st.cnt[1][15:8], mf_cnt, al_cnt};
		end else begin
			bumped[1] = inc3 ? sat_inc(st.cnt[1]) : st.cnt[1];
		end

		// buffer and clearing scheme, shared by both counters
		rise = st.freeze & ~st.freeze_d;
		next_st.freeze_d = st.freeze;
		for (int i = 0; i < 2; i++) begin
			if (st.ctrl[CTL_PER_SECOND]) begin
				if (one_second_event) begin
					next_st.buff[i] = st.cnt[i]; // see (R9)
					next_st.cnt[i] = 16'h0000;
				end else begin
					next_st.cnt[i] = bumped[i];
				end
			end else begin
				next_st.cnt[i] = rise[i] ? 16'h0000 : bumped[i]; // see (R8)
				if (!st.freeze[i] && !rise[i]) begin
					next_st.buff[i] = st.cnt[i]; // see (R7) see (R8)
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.ctrl <= CTL_RESET;
			st.freeze <= FREEZE_RESET;
			st.signalling_low_changed_bits <= SIG_FLAGS_RESET;
			st.signalling_high_changed_bits <= SIG_FLAGS_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign sixth_spare_changed_event = sa6_changed; // see (R19)
endmodule : e1_sa_bit_error_monitor

// ==== e1_sa_bit_error_monitor_tb_top.sv ====
// testbench for the sa-bit capture and error counter monitor
`timescale 1ns/10ps
module e1_sa_bit_error_monitor_tb_top;
	import e1_sa_monitor_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, sa_strobe, multiframe_begin_event, sixth_spare_changed_event, busy;
	logic [3:0] frame_number, signalling_index = '0;
	logic [4:0] sa_bits;
	logic [39:0] pattern = '0;
	logic frame_align_lost = 0, multiframe_align_lost = 0, alignment_change = 0;
	logic rx_bit_strobe = 0, prbs_bit_error = 0, prbs_sync_indication = 0;
	logic one_second_event = 0, signalling_update = 0, err;
	int num_errors = 0, n_compared = 0, n_changed = 0;
	logic [7:0] cls [6] = '{8'h11, 8'h55, 8'h33, 8'h77, 8'hFF, 8'h22};
	always #4 pclk = ~pclk;
	always @(posedge pclk) if (sixth_spare_changed_event === 1'b1) n_changed++;
	e1_sa_bit_error_monitor dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sa_strobe, .frame_number, .sa_bits,
		.multiframe_begin_event, .frame_align_lost, .multiframe_align_lost, .alignment_change,
		.rx_bit_strobe, .prbs_bit_error, .prbs_sync_indication, .one_second_event,
		.signalling_update, .signalling_index, .sixth_spare_changed_event);
	e1_line_model line_u (.pclk, .presetn, .go, .pattern, .sa_strobe, .frame_number,
		.sa_bits, .multiframe_begin_event, .busy);
	task print_verdict;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			num_errors++;
			print_verdict();
		end
		// answer taken at the completing edge, then the request is released
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd_chk(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check(rd, exp);
	endtask : rd_chk
	task send_mf(input logic [39:0] p);
		int i;
		pattern <= p;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		for (i = 0; i < 60; i++) begin
			@(negedge pclk);
			if (busy === 1'b0) break;
		end
		if (i == 60) begin
			num_errors++;
			print_verdict();
		end
		repeat (2) @(posedge pclk);
	endtask : send_mf
	task counts(input logic [15:0] e2, input logic [15:0] e3, input bit frz, input bit cmp);
		logic [15:0] v2;
		logic [15:0] v3;
		if (frz) apb(1'b1, IDX_FREEZE, 32'h3);
		apb(1'b0, IDX_CNT2_LOW, 32'h0);
		v2[7:0] = rd[7:0];
		apb(1'b0, IDX_CNT2_HIGH, 32'h0);
		v2[15:8] = rd[7:0];
		apb(1'b0, IDX_CNT3_LOW, 32'h0);
		v3[7:0] = rd[7:0];
		apb(1'b0, IDX_CNT3_HIGH, 32'h0);
		v3[15:8] = rd[7:0];
		if (cmp) begin
			check({16'h0, v2}, {16'h0, e2});
			check({16'h0, v3}, {16'h0, e3});
			rd_chk(IDX_FREEZE, 32'h0);
		end
	endtask : counts
	task errs(input int n);
		repeat (n) begin
			rx_bit_strobe <= 1'b1;
			prbs_bit_error <= 1'b1;
			@(posedge pclk);
			rx_bit_strobe <= 1'b0;
			prbs_bit_error <= 1'b0;
			@(posedge pclk);
		end
	endtask : errs
	task sec;
		one_second_event <= 1'b1;
		@(posedge pclk);
		one_second_event <= 1'b0;
	endtask : sec
	task t_reset;
		rd_chk(IDX_SIG_FLAGS_LOW, 32'h0);
		rd_chk(IDX_SIG_FLAGS_HIGH, 32'h0);
		rd_chk(IDX_CONTROL, 32'h0);
		apb(1'b0, 10'h000, 32'h0);
		check({31'h0, err}, 32'h1);
	endtask : t_reset
	task t_capture;
		apb(1'b1, IDX_CONTROL, 32'h10);
		send_mf(40'h965AC83CA5);
		apb(1'b1, IDX_RX_SA4, 32'h0);
		for (int i = 0; i < 5; i++) rd_chk(IDX_RX_SA4 + 10'(i), 32'(pattern[i * 8 +: 8]));
		counts(16'h2, 16'h1, 1'b1, 1'b1);
		multiframe_align_lost <= 1'b1;
		send_mf(40'h965AC83CA5);
		counts(16'h0, 16'h0, 1'b1, 1'b1);
		multiframe_align_lost <= 1'b0;
	endtask : t_capture
	task t_sa6;
		apb(1'b0, IDX_SA6_STATUS, 32'h0);
		n_changed = 0;
		for (int i = 0; i < 6; i++) begin
			send_mf({16'h0, cls[i], 16'h0});
			rd_chk(IDX_SA6_STATUS, 32'h0);
			send_mf({16'h0, cls[i], 16'h0});
			rd_chk(IDX_SA6_STATUS, 32'h1 << i);
		end
		check(32'(n_changed), 32'h6);
		frame_align_lost <= 1'b1;
		repeat (2) send_mf({16'h0, 8'hFF, 16'h0});
		frame_align_lost <= 1'b0;
		rd_chk(IDX_SA6_STATUS, 32'h0);
		apb(1'b1, IDX_CONTROL, 32'h18);
		multiframe_align_lost <= 1'b1;
		repeat (2) send_mf({16'h0, 8'h33, 16'h0});
		multiframe_align_lost <= 1'b0;
		rd_chk(IDX_SA6_STATUS, 32'h0);
	endtask : t_sa6
	task t_modes;
		apb(1'b1, IDX_CONTROL, 32'h30);
		counts(16'h0, 16'h0, 1'b1, 1'b0);
		send_mf({16'h0, 8'h11, 16'h0});
		counts(16'h2, 16'h2, 1'b1, 1'b1);
		apb(1'b1, IDX_CONTROL, 32'h14);
		counts(16'h0, 16'h0, 1'b1, 1'b0);
		repeat (5) begin
			alignment_change <= 1'b1;
			@(posedge pclk);
			alignment_change <= 1'b0;
			@(posedge pclk);
		end
		frame_align_lost <= 1'b1;
		repeat (3) send_mf(40'h0);
		frame_align_lost <= 1'b0;
		counts(16'h0, 16'h000F, 1'b1, 1'b1);
	endtask : t_modes
	task t_prbs;
		apb(1'b1, IDX_CONTROL, 32'h11);
		counts(16'h0, 16'h0, 1'b1, 1'b0);
		prbs_sync_indication <= 1'b1;
		errs(4);
		prbs_sync_indication <= 1'b0;
		errs(2);
		counts(16'h4, 16'h0, 1'b1, 1'b1);
		apb(1'b1, IDX_CONTROL, 32'h31);
		counts(16'h0, 16'h0, 1'b1, 1'b0);
		rx_bit_strobe <= 1'b1;
		repeat (10) @(posedge pclk);
		rx_bit_strobe <= 1'b0;
		counts(16'h5, 16'h0, 1'b1, 1'b1);
		apb(1'b1, IDX_CONTROL, 32'h13);
		prbs_sync_indication <= 1'b1;
		sec();
		errs(3);
		sec();
		errs(2);
		counts(16'h3, 16'h0, 1'b0, 1'b1);
		sec();
		counts(16'h2, 16'h0, 1'b0, 1'b1);
	endtask : t_prbs
	task t_signalling;
		foreach (cls[i]) if (i < 4) begin
			signalling_index <= 4'(i[1] ? 8 + 7 * i[0] : 7 * i[0]);
			signalling_update <= 1'b1;
			@(posedge pclk);
			signalling_update <= 1'b0;
			@(posedge pclk);
		end
		rd_chk(IDX_SIG_FLAGS_LOW, 32'h81);
		rd_chk(IDX_SIG_FLAGS_HIGH, 32'h81);
		rd_chk(IDX_SIG_FLAGS_LOW, 32'h0);
	endtask : t_signalling
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_capture();
		t_sa6();
		t_modes();
		t_prbs();
		t_signalling();
		print_verdict();
	end
endmodule : e1_sa_bit_error_monitor_tb_top

// ==== e1_sa_line_model.sv ====
// partner model: received service-word stream, one multiframe per request
`timescale 1ns/10ps
module e1_line_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [39:0] pattern,
	output logic sa_strobe,
	output logic [3:0] frame_number,
	output logic [4:0] sa_bits,
	output logic multiframe_begin_event,
	output logic busy
);
	logic [5:0] step;
	assign busy = step != 6'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step <= 6'h00;
			sa_strobe <= 1'b0;
			frame_number <= 4'h0;
			sa_bits <= 5'h00;
			multiframe_begin_event <= 1'b0;
		end else begin
			sa_strobe <= 1'b0;
			multiframe_begin_event <= 1'b0;
			// lines outside a strobe toggle so stale bits never pass for data
			sa_bits <= ~sa_bits;
			frame_number <= frame_number + 4'h1;
			if (go && !busy) begin
				step <= 6'h01;
			end else if (busy) begin
				step <= step + 6'h01;
				if (step[0] && step <= 6'h1F) begin
					sa_strobe <= 1'b1;
					frame_number <= step[4:1];
					// even frames carry inverted bits, odd frames the pattern
					for (int i = 0; i < 5; i++) begin
						sa_bits[i] <= pattern[i * 8 + step[4:2]] ^ !step[1];
					end
				end
				if (step == 6'h21) begin
					multiframe_begin_event <= 1'b1;
					step <= 6'h00;
				end
			end
		end
	end
endmodule : e1_line_model

// ==== e1_sa_monitor_pkg.sv ====
// constants shared by the spare-bit and error-count monitor
package e1_sa_monitor_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_RX_SA4 = 10'h05C;
	localparam logic [9:0] IDX_RX_SA5 = 10'h05D;
	localparam logic [9:0] IDX_RX_SA6 = 10'h05E;
	localparam logic [9:0] IDX_RX_SA7 = 10'h05F;
	localparam logic [9:0] IDX_RX_SA8 = 10'h060;
	localparam logic [9:0] IDX_SA6_STATUS = 10'h061;
	localparam logic [9:0] IDX_SIG_FLAGS_LOW = 10'h062;
	localparam logic [9:0] IDX_SIG_FLAGS_HIGH = 10'h063;
	localparam logic [9:0] IDX_CNT2_LOW = 10'h050;
	localparam logic [9:0] IDX_CNT2_HIGH = 10'h051;
	localparam logic [9:0] IDX_CNT3_LOW = 10'h052;
	localparam logic [9:0] IDX_CNT3_HIGH = 10'h053;
	localparam logic [9:0] IDX_CONTROL = 10'h054;
	localparam logic [9:0] IDX_FREEZE = 10'h055;

	// control register fields
	localparam int CTL_PRBS_MODE = 0;
	localparam int CTL_PER_SECOND = 1;
	localparam int CTL_CNT3_MODE = 2;
	localparam int CTL_SA6_SYNC = 3;
	localparam int CTL_CRC_FORMAT = 4;
	localparam int CTL_ALARM_SIM = 5;
	localparam logic [5:0] CTL_RESET = 6'h00;
	localparam logic [1:0] FREEZE_RESET = 2'h0;
	localparam logic [7:0] SIG_FLAGS_RESET = 8'h00;

	// sa6 class numbers, equal to their status bit positions
	localparam logic [2:0] CLS_1000 = 3'h0;
	localparam logic [2:0] CLS_1010 = 3'h1;
	localparam logic [2:0] CLS_1100 = 3'h2;
	localparam logic [2:0] CLS_1110 = 3'h3;
	localparam logic [2:0] CLS_1111 = 3'h4;
	localparam logic [2:0] CLS_OTHER = 3'h5;
	localparam logic [2:0] CLS_NONE = 3'h7;
	localparam logic [1:0] SA6_REPEATS = 2'h3;

	// sa6 sequences counted by the two error counters
	localparam logic [3:0] SEQ_REMOTE = 4'h1;
	localparam logic [3:0] SEQ_LOCAL = 4'h2;
	localparam logic [3:0] SEQ_BOTH = 4'h3;

	// frames that open a submultiframe and close one
	localparam logic [3:0] FRAME_SMF1_FIRST = 4'h1;
	localparam logic [3:0] FRAME_SMF2_FIRST = 4'h9;
	localparam logic [3:0] FRAME_SMF1_LAST = 4'h7;
	localparam logic [3:0] FRAME_SMF2_LAST = 4'hF;

	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [5:0] MF_CNT_MAX = 6'h3F;
	localparam logic [1:0] ALIGN_CNT_MAX = 2'h3;
endpackage : e1_sa_monitor_pkg

// ==== e1_sa_port_monitor.sv ====
// port checker for the sa-bit monitor
`timescale 1ns/10ps
module sa_port_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [e1_sa_monitor_pkg::ADDR_W-1:0] paddr,
	input wire logic [e1_sa_monitor_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic frame_align_lost,
	input wire logic sixth_spare_changed_event
);
	import e1_sa_monitor_pkg::*;
	logic [9:0] idx;
	logic mapped;
	assign idx = paddr[11:2];
	assign mapped = (idx >= IDX_CNT2_LOW && idx <= IDX_FREEZE) ||
		(idx >= IDX_RX_SA4 && idx <= IDX_SIG_FLAGS_HIGH);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	a_one_wait_state: assert property (s_wait |=> s_done)
		else $error("no answer after one wait state");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_no_setup_ready: assert property ($rose(psel) |-> !pready)
		else $error("pready in setup cycle");
	a_error_decode: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match decode");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_change_one_pulse: assert property (sixth_spare_changed_event |=>
		!sixth_spare_changed_event) else $error("change event longer than one cycle");
	a_lost_no_change: assert property (frame_align_lost [*3] |->
		!sixth_spare_changed_event) else $error("change event while frame lost");
endmodule : sa_port_checker

bind e1_sa_bit_error_monitor sa_port_checker chk_u (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .frame_align_lost, .sixth_spare_changed_event);

// ==== sa6_pattern_detector.sv ====
// sa6 four-bit pattern classifier with sticky status and change pulse
`timescale 1ns/10ps
module sa6_pattern_detector (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sa6_strobe,
	input wire logic sa6_bit,
	input wire logic smf_first,
	input wire logic frame_align_lost,
	input wire logic multiframe_align_lost,
	input wire logic sixth_spare_sync_detect,
	input wire logic [5:0] clear_mask,
	output logic [5:0] status,
	output logic changed
);
	import e1_sa_monitor_pkg::*;

	typedef struct packed {
		logic [3:0] nib;
		logic [1:0] pos;
		logic [2:0] last_cls;
		logic [1:0] rep;
		logic [2:0] cur_cls;
		logic [5:0] status;
		logic changed;
	} det_t;

	det_t st;
	det_t next_st;

	function automatic logic [2:0] classify(input logic [3:0] n);
		unique case (n)
			4'h8: return CLS_1000;
			4'hA: return CLS_1010;
			4'hC: return CLS_1100;
			4'hE: return CLS_1110;
			4'hF: return CLS_1111;
			default: return CLS_OTHER; // see (R16)
		endcase
	endfunction : classify

	always_comb begin
		logic [1:0] pos;
		logic [3:0] nib;
		logic [2:0] cls;
		logic [1:0] rep;
		logic enable;
		logic [5:0] set_bits;
		pos = 2'h0;
		nib = 4'h0;
		cls = CLS_NONE;
		rep = 2'h0;
		set_bits = 6'h00;
		next_st = st;
		next_st.changed = 1'b0;
		enable = !frame_align_lost && (!sixth_spare_sync_detect || !multiframe_align_lost); // see (R20) see (R21)
		if (sa6_strobe) begin
			// synchronous detection restarts each group at a submultiframe
			pos = (sixth_spare_sync_detect && smf_first) ? 2'h0 : st.pos;
			nib = {st.nib[2:0], sa6_bit};
			next_st.nib = nib;
			next_st.pos = pos + 2'h1;
			if (pos == 2'h3) begin
				cls = classify(nib); // see (R16)
				rep = (cls == st.last_cls && st.rep != SA6_REPEATS) ? st.rep + 2'h1 :
					(cls == st.last_cls ? st.rep : 2'h1);
				next_st.last_cls = cls;
				next_st.rep = rep;
				if (rep == SA6_REPEATS && enable) begin // see (R17)
					set_bits[cls] = 1'b1;
					if (cls != st.cur_cls) begin
						next_st.cur_cls = cls;
						next_st.changed = 1'b1; // see (R19)
					end
				end
			end
		end
		next_st.status = (st.status & ~clear_mask) | set_bits; // see (R18)
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{nib: 4'h0, pos: 2'h0, last_cls: CLS_NONE, rep: 2'h0,
				cur_cls: CLS_NONE, status: 6'h00, changed: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign status = st.status;
	assign changed = st.changed;
endmodule : sa6_pattern_detector
